//--- hdl/biop_pkg.sv
// constants, build options and register layout of the bidirectional i/o port block
package biop_pkg;

    // ======================================================================
    // build-time output driver options
    // ======================================================================
    typedef enum logic [1:0] {
        BIOP_PUSHPULL  = 2'h0,  // complementary output, pull-up fitted
        BIOP_OD_PULLUP = 2'h1,  // open drain, pull-up fitted
        BIOP_OD_NOPULL = 2'h2   // open drain, no pull-up
    } biop_opt_t;

    // ======================================================================
    // geometry
    // ======================================================================
    localparam int NUM_PORTS  = 3;
    localparam int PORT_BITS  = 4;
    localparam int NUM_PINS   = NUM_PORTS * PORT_BITS;
    localparam int SYNC_DEPTH = 2;

    // ======================================================================
    // register map (byte addresses on the axi4-lite bus)
    // ======================================================================
    localparam logic [7:0] OFS_PORT0   = 8'h00;
    localparam logic [7:0] OFS_PORT1   = 8'h10;
    localparam logic [7:0] OFS_PORT2   = 8'h20;
    localparam logic [7:0] OFS_SERCTRL = 8'h30;
    localparam logic [7:0] OFS_DIR     = 8'h00;  // within a port block
    localparam logic [7:0] OFS_PULL    = 8'h04;
    localparam logic [7:0] OFS_DATA    = 8'h08;
    localparam int         ADDR_W      = 8;

    // serial control register fields
    localparam int SERCTRL_EN_BIT    = 0;
    localparam int SERCTRL_SLAVE_BIT = 1;

    // port 1 pin roles while the serial interface is enabled
    localparam int P1_SDATA_IN  = 0;
    localparam int P1_SDATA_OUT = 1;
    localparam int P1_SCLK      = 2;
    localparam int P1_SREADY    = 3;

    // ======================================================================
    // reset values
    // ======================================================================
    localparam logic [3:0] RST_DIR   = 4'h0;
    localparam logic [3:0] RST_PULL  = 4'hF;
    localparam logic [3:0] RST_DATA  = 4'h0;
    localparam logic       RST_SEREN = 1'b0;
    localparam logic       RST_SLAVE = 1'b0;

    // ======================================================================
    // bus answers
    // ======================================================================
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // a pull-up resistor exists for this option
    function automatic logic pullFitted(input biop_opt_t opt);
        pullFitted = (opt != BIOP_OD_NOPULL);
    endfunction

endpackage

//--- hdl/biop_pin_cell.sv
// output driver and pull-up control of one port pin
`timescale 1ns/1ps
module biop_pin_cell #(
    parameter biop_pkg::biop_opt_t OPT = biop_pkg::BIOP_PUSHPULL
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic dirOut,
    input  wire logic dataOut,
    input  wire logic pullEn,
    output logic      pinOut,
    output logic      pinOe,
    output logic      pullOn
);

    logic nxt_pinOe;
    logic nxt_pinOut;
    logic nxt_pullOn;
    logic pinOut_ff;
    logic pinOe_ff;
    logic pullOn_ff;

    // ======================================================================
    // driver decode
    // ======================================================================
    // open drain only ever pulls low; a high is left to the pull-up or board
    always_comb begin
        if (OPT == biop_pkg::BIOP_PUSHPULL) begin
            nxt_pinOe  = dirOut;
            nxt_pinOut = dataOut;
        end else begin
            nxt_pinOe  = dirOut & ~dataOut;
            nxt_pinOut = 1'b0;
        end
        // pull-up only in input mode and only where one is built in
        nxt_pullOn = biop_pkg::pullFitted(OPT) & pullEn & ~dirOut;
    end

    // registered pad controls keep glitches off the pins
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pinOut_ff <= 1'b0;
            pinOe_ff  <= 1'b0;
            pullOn_ff <= 1'b0;
        end else if (ce) begin
            pinOut_ff <= nxt_pinOut;
            pinOe_ff  <= nxt_pinOe;
            pullOn_ff <= nxt_pullOn;
        end
    end

    assign pinOut = pinOut_ff;
    assign pinOe  = pinOe_ff;
    assign pullOn = pullOn_ff;

endmodule // biop_pin_cell

//--- hdl/biop_ctrl.sv
// bidirectional i/o port controller with axi4-lite register access
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module biop_ctrl #(
    parameter biop_pkg::biop_opt_t PORT0_OPT = biop_pkg::BIOP_PUSHPULL,
    parameter biop_pkg::biop_opt_t PORT1_OPT = biop_pkg::BIOP_PUSHPULL,
    parameter logic [7:0]          PORT2_OPT = 8'h00
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        ce,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // port pins: 0-3 port 0, 4-7 port 1, 8-11 port 2
    input  wire logic [11:0] pinIn,
    output logic [11:0]      pinOut,
    output logic [11:0]      pinOe,
    output logic [11:0]      pinPullOn,
    // serial interface unit side
    input  wire logic        serialDataOut,
    input  wire logic        serialClkOut,
    input  wire logic        serialReadyOut,
    output logic             serialDataIn,
    output logic             serialClkIn,
    output logic             serialIfEnable,
    output logic             serialSlaveMode
);

    // ======================================================================
    // storage
    // ======================================================================
    logic [3:0]  dir_ff  [biop_pkg::NUM_PORTS];
    logic [3:0]  pull_ff [biop_pkg::NUM_PORTS];
    logic [3:0]  data_ff [biop_pkg::NUM_PORTS];
    logic        serEn_ff;
    logic        serSlave_ff;
    logic [11:0] syncA_ff;
    logic [11:0] syncB_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] rdata_ff;

    logic        wrFire;
    logic        rdFire;
    logic [3:0]  takenP1;
    logic [11:0] effDir;
    logic [11:0] effData;
    logic [11:0] effPull;
    logic [31:0] nxt_rdata;
    logic        nxt_rdOk;

    // ======================================================================
    // helpers
    // ======================================================================
    // address is one of the nine port registers or the serial control word
    function automatic logic addrValid(input logic [7:0] a);
        logic [7:0] portPart;
        logic [7:0] kindPart;
        portPart  = {2'h0, a[5:4], 4'h0};
        kindPart  = {4'h0, a[3:0]};
        addrValid = (a == biop_pkg::OFS_SERCTRL) ||
                    (a[7:6] == 2'h0 && portPart <= biop_pkg::OFS_PORT2 &&
                     (kindPart == biop_pkg::OFS_DIR || kindPart == biop_pkg::OFS_PULL ||
                      kindPart == biop_pkg::OFS_DATA));
    endfunction

    // data read-back: stored bit when driving or when the pin is taken
    function automatic logic [3:0] readBack(input logic [3:0] dir,
                                            input logic [3:0] stored,
                                            input logic [3:0] live,
                                            input logic [3:0] taken);
        readBack = ((dir | taken) & stored) | (~(dir | taken) & live);
    endfunction

    // ======================================================================
    // write channel: address and data taken together in one cycle
    // ======================================================================
    // waiting for both keeps the slave stateless; either arrival order works
    assign wrFire        = ce & s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
    assign s_axi_awready = wrFire;
    assign s_axi_wready  = wrFire;

    // register writes, one nibble per port register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < biop_pkg::NUM_PORTS; p++) begin
                dir_ff[p]  <= biop_pkg::RST_DIR;
                pull_ff[p] <= biop_pkg::RST_PULL;
                data_ff[p] <= biop_pkg::RST_DATA;
            end
        end else if (wrFire && s_axi_wstrb[0]) begin
            for (int p = 0; p < biop_pkg::NUM_PORTS; p++) begin
                if (s_axi_awaddr[5:4] == p[1:0] && s_axi_awaddr[7:6] == 2'h0) begin
                    case ({4'h0, s_axi_awaddr[3:0]})
                        biop_pkg::OFS_DIR:  dir_ff[p]  <= s_axi_wdata[3:0];
                        biop_pkg::OFS_PULL: pull_ff[p] <= s_axi_wdata[3:0];
                        biop_pkg::OFS_DATA: data_ff[p] <= s_axi_wdata[3:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // serial mode control
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            serEn_ff    <= biop_pkg::RST_SEREN;
            serSlave_ff <= biop_pkg::RST_SLAVE;
        end else if (wrFire && s_axi_wstrb[0] && s_axi_awaddr == biop_pkg::OFS_SERCTRL) begin
            serEn_ff    <= s_axi_wdata[biop_pkg::SERCTRL_EN_BIT];
            serSlave_ff <= s_axi_wdata[biop_pkg::SERCTRL_SLAVE_BIT];
        end
    end

    // write response, unmapped addresses answer slverr and change nothing
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= biop_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wrFire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= addrValid(s_axi_awaddr) ? biop_pkg::RESP_OKAY
                                                     : biop_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // ======================================================================
    // input synchroniser
    // ======================================================================
    // pins are asynchronous to clk_sys; only syncB_ff is read downstream
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            syncA_ff <= 12'h000;
            syncB_ff <= 12'h000;
        end else if (ce) begin
            syncA_ff <= pinIn;
            syncB_ff <= syncA_ff;
        end
    end

    // ======================================================================
    // read channel
    // ======================================================================
    assign rdFire        = ce & s_axi_arvalid & ~rvalid_ff;
    assign s_axi_arready = rdFire;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rdOk  = addrValid(s_axi_araddr);
        if (s_axi_araddr == biop_pkg::OFS_SERCTRL) begin
            nxt_rdata[biop_pkg::SERCTRL_EN_BIT]    = serEn_ff;
            nxt_rdata[biop_pkg::SERCTRL_SLAVE_BIT] = serSlave_ff;
        end else if (nxt_rdOk) begin
            for (int p = 0; p < biop_pkg::NUM_PORTS; p++) begin
                if (s_axi_araddr[5:4] == p[1:0]) begin
                    case ({4'h0, s_axi_araddr[3:0]})
                        biop_pkg::OFS_DIR:  nxt_rdata[3:0] = dir_ff[p];
                        biop_pkg::OFS_PULL: nxt_rdata[3:0] = pull_ff[p];
                        biop_pkg::OFS_DATA: nxt_rdata[3:0] = readBack(
                                                dir_ff[p], data_ff[p],
                                                syncB_ff[4*p +: 4],
                                                (p == 1) ? takenP1 : 4'h0);
                        default: ;
                    endcase
                end
            end
        end
    end

    // read data is captured at the address handshake
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= biop_pkg::RESP_OKAY;
            rdata_ff  <= 32'h0000_0000;
        end else if (ce) begin
            if (rdFire) begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= nxt_rdOk ? biop_pkg::RESP_OKAY : biop_pkg::RESP_SLVERR;
                rdata_ff  <= nxt_rdata;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp  = rresp_ff;
    assign s_axi_rdata  = rdata_ff;

    // ======================================================================
    // pin function selection
    // ======================================================================
    // bits 0-2 go to the serial unit when enabled, bit 3 only in slave mode
    assign takenP1 = serEn_ff ? {serSlave_ff, 3'h7} : 4'h0;

    always_comb begin
        effDir  = {dir_ff[2], dir_ff[1], dir_ff[0]};
        effData = {data_ff[2], data_ff[1], data_ff[0]};
        effPull = {pull_ff[2], pull_ff[1], pull_ff[0]};
        if (serEn_ff) begin
            // serial data input: pull-up bit stays live
            effDir[4 + biop_pkg::P1_SDATA_IN]   = 1'b0;
            effPull[4 + biop_pkg::P1_SDATA_IN]  = pull_ff[1][0];
            // serial data output: pull-up bit is storage only
            effDir[4 + biop_pkg::P1_SDATA_OUT]  = 1'b1;
            effData[4 + biop_pkg::P1_SDATA_OUT] = serialDataOut;
            effPull[4 + biop_pkg::P1_SDATA_OUT] = 1'b0;
            // serial clock: output as master, input with live pull-up as slave
            effDir[4 + biop_pkg::P1_SCLK]       = ~serSlave_ff;
            effData[4 + biop_pkg::P1_SCLK]      = serialClkOut;
            effPull[4 + biop_pkg::P1_SCLK]      = serSlave_ff & pull_ff[1][2];
            if (serSlave_ff) begin
                effDir[4 + biop_pkg::P1_SREADY]  = 1'b1;
                effData[4 + biop_pkg::P1_SREADY] = serialReadyOut;
                effPull[4 + biop_pkg::P1_SREADY] = 1'b0;
            end
        end
    end

    // synchronised serial inputs back to the serial unit
    assign serialDataIn    = syncB_ff[4 + biop_pkg::P1_SDATA_IN];
    assign serialClkIn     = syncB_ff[4 + biop_pkg::P1_SCLK];
    assign serialIfEnable  = serEn_ff;
    assign serialSlaveMode = serSlave_ff;

    // ======================================================================
    // pad cells
    // ======================================================================
    // ports 0 and 1 share one option per nibble, port 2 has one per pin
    for (genvar i = 0; i < biop_pkg::NUM_PINS; i++) begin : g_pin
        localparam biop_pkg::biop_opt_t CELL_OPT =
            (i < 4) ? PORT0_OPT :
            (i < 8) ? PORT1_OPT :
            biop_pkg::biop_opt_t'(PORT2_OPT[2*(i%4) +: 2]);

        biop_pin_cell #(
            .OPT (CELL_OPT)
        ) u_cell (
            .clk_sys (clk_sys),
            .resetn  (resetn),
            .ce      (ce),
            .dirOut  (effDir[i]),
            .dataOut (effData[i]),
            .pullEn  (effPull[i]),
            .pinOut  (pinOut[i]),
            .pinOe   (pinOe[i]),
            .pullOn  (pinPullOn[i])
        );
    end

endmodule // biop_ctrl

//--- verification/biop_pin_model.sv
// board-side model of the twelve port pins
`timescale 1ns/1ps
module biop_pin_model (
    input  wire logic        clk_sys,
    input  wire logic [11:0] pinOut,
    input  wire logic [11:0] pinOe,
    input  wire logic [11:0] pinPullOn,
    input  wire logic [11:0] extLevel,
    input  wire logic [11:0] extEn,
    output logic      [11:0] pinLevel
);
    logic [11:0] floatPat = 12'hA5A;
    // an undriven pin wanders; never trust its last level
    always @(posedge clk_sys) floatPat <= ~floatPat;
    // device driver beats board, board beats pull-up
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (pinOe[i]) pinLevel[i] = pinOut[i];
            else if (extEn[i]) pinLevel[i] = extLevel[i];
            else if (pinPullOn[i]) pinLevel[i] = 1'b1;
            else pinLevel[i] = floatPat[i];
        end
    end
endmodule // biop_pin_model

//--- verification/biop_ctrl_properties.sv
// concurrent checks on pins and bus answers of the port controller
`timescale 1ns/1ps
module biop_ctrl_properties #(
    parameter biop_pkg::biop_opt_t PORT0_OPT = biop_pkg::BIOP_PUSHPULL,
    parameter biop_pkg::biop_opt_t PORT1_OPT = biop_pkg::BIOP_PUSHPULL,
    parameter logic [7:0]          PORT2_OPT = 8'h00
) (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        ce,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [11:0] pinIn,
    input wire logic [11:0] pinOut,
    input wire logic [11:0] pinOe,
    input wire logic [11:0] pinPullOn,
    input wire logic        serialDataOut,
    input wire logic        serialReadyOut,
    input wire logic        serialDataIn,
    input wire logic        serialIfEnable,
    input wire logic        serialSlaveMode
);
    // ======================================================================
    // open-drain pins never drive high, bare pins get no pull
    // ======================================================================
    localparam logic P1OD = PORT1_OPT != biop_pkg::BIOP_PUSHPULL;
    localparam logic [11:0] ODM = {PORT2_OPT[7:6] != 2'h0, PORT2_OPT[5:4] != 2'h0,
        PORT2_OPT[3:2] != 2'h0, PORT2_OPT[1:0] != 2'h0, {4{P1OD}},
        {4{PORT0_OPT != biop_pkg::BIOP_PUSHPULL}}};
    localparam logic [11:0] BARE = {PORT2_OPT[7:6] == 2'h2, PORT2_OPT[5:4] == 2'h2,
        PORT2_OPT[3:2] == 2'h2, PORT2_OPT[1:0] == 2'h2,
        {4{PORT1_OPT == biop_pkg::BIOP_OD_NOPULL}}, {4{PORT0_OPT == biop_pkg::BIOP_OD_NOPULL}}};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ======================================================================
    // sequences
    // ======================================================================
    sequence serialOn;
        ce && serialIfEnable;
    endsequence
    sequence slaveOn;
        ce && serialIfEnable && serialSlaveMode;
    endsequence
    // four quiet samples cover both synchroniser stages
    sequence pinHeld;
        (ce && serialIfEnable && $stable(pinIn[4])) [*4];
    endsequence

    // ======================================================================
    // assertions
    // ======================================================================
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid |=> s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ce_freeze: assert property (!ce |-> !s_axi_arready && !s_axi_awready)
        else $error("request taken with ce low");
    a_pull_out_off: assert property ((pinOe & pinPullOn) == 12'h000)
        else $error("pull-up on driven pin");
    a_bare_no_pull: assert property ((pinPullOn & BARE) == 12'h000)
        else $error("pull-up on a bare pin");
    a_od_low_only: assert property ((pinOe & pinOut & ODM) == 12'h000)
        else $error("open drain driven high");
    a_serial_data_out_follows: assert property (serialOn |=> !pinPullOn[5] &&
        pinOe[5] == (P1OD ? !$past(serialDataOut) : 1'b1))
        else $error("serial out pin wrong");
    a_ready_slave: assert property (slaveOn |=> !pinPullOn[7] &&
        pinOe[7] == (P1OD ? !$past(serialReadyOut) : 1'b1))
        else $error("serial ready pin wrong");
    a_sync_input: assert property (pinHeld |-> serialDataIn == pinIn[4])
        else $error("serial data in stale");
endmodule // biop_ctrl_properties

bind biop_ctrl biop_ctrl_properties #(.PORT0_OPT(PORT0_OPT), .PORT1_OPT(PORT1_OPT),
    .PORT2_OPT(PORT2_OPT)) biop_ctrl_properties_i (.clk_sys, .resetn, .ce, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .pinIn, .pinOut, .pinOe, .pinPullOn, .serialDataOut, .serialReadyOut,
    .serialDataIn, .serialIfEnable, .serialSlaveMode);

//--- verification/biop_ctrl_bench.sv
// self-checking bench of the port controller against a register model
`timescale 1ns/1ps
module biop_ctrl_bench;
    localparam logic [11:0] ODM  = 12'h6F0; // open-drain pins of this build
    localparam logic [11:0] FITM = 12'hBFF; // pins with a pull-up fitted
    logic        clk_sys = 1'b0, resetn = 1'b0, ce = 1'b1, awV = 1'b0, wV = 1'b0;
    logic        bRdy = 1'b0, arV = 1'b0, rRdy = 1'b0, sdo = 1'b0, sco = 1'b0, sro = 1'b0;
    logic [7:0]  awA = 8'h00, arA = 8'h00;
    logic [31:0] wD = 32'h0, rD;
    logic [3:0]  wS = 4'hF;
    logic [11:0] extLevel = 12'h000, extEn = 12'h000, pinLv, pinOut, pinOe, pinPullOn;
    logic        awR, wR, bV, arR, rV, sdi, sci, serEn, serSl;
    logic [1:0]  bResp, rResp;
    int          fail_count = 0, n_tests = 0, cycles = 0, serM = 0;
    int          dirM[3] = '{0, 0, 0}, pullM[3] = '{15, 15, 15}, dataM[3] = '{0, 0, 0};

    biop_ctrl #(.PORT1_OPT(biop_pkg::BIOP_OD_PULLUP), .PORT2_OPT(8'h24)) biop_ctrl_i (
        .clk_sys, .resetn, .ce, .s_axi_awaddr(awA), .s_axi_awvalid(awV),
        .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV),
        .s_axi_wready(wR), .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
        .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD),
        .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rRdy), .pinIn(pinLv),
        .pinOut, .pinOe, .pinPullOn, .serialDataOut(sdo),
        .serialClkOut(sco), .serialReadyOut(sro), .serialDataIn(sdi), .serialClkIn(sci),
        .serialIfEnable(serEn), .serialSlaveMode(serSl));
    biop_pin_model biop_pin_model_i (.clk_sys, .pinOut, .pinOe, .pinPullOn, .extLevel, .extEn,
        .pinLevel(pinLv));

    // 100 MHz clock; serial unit outputs wander to exercise both levels
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) {sdo, sco, sro} <= 3'($urandom);
    // a hung handshake ends the run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    // ======================================================================
    // checking and bus tasks
    // ======================================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [31:0] respOf(input logic [7:0] a);
        logic ok;
        ok = a == 8'h30 || (a[7:4] < 4'h3 && a[3:0] <= 4'h8 && a[1:0] == 2'h0);
        return {30'h0, ok ? biop_pkg::RESP_OKAY : biop_pkg::RESP_SLVERR};
    endfunction
    function automatic logic [11:0] nib(input int v[3]);
        return {v[2][3:0], v[1][3:0], v[0][3:0]};
    endfunction
    // write: address and data held together until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int p;
        p = int'(a[5:4]);
        awA <= a;
        wD <= d;
        wS <= s;
        awV <= 1'b1;
        wV <= 1'b1;
        do @(posedge clk_sys); while (awR !== 1'b1 || wR !== 1'b1);
        awV <= 1'b0;
        wV <= 1'b0;
        bRdy <= 1'b1;
        do @(posedge clk_sys); while (bV !== 1'b1);
        bRdy <= 1'b0;
        chk({30'h0, bResp}, respOf(a));
        if (respOf(a) == 32'h0 && s[0]) begin
            if (a == 8'h30) serM = d[1:0];
            else if (a[3:0] == 4'h0) dirM[p] = d[3:0];
            else if (a[3:0] == 4'h4) pullM[p] = d[3:0];
            else dataM[p] = d[3:0];
        end
    endtask
    // read: driven or serial pins give the stored bit, inputs the pin
    task automatic rd(input logic [7:0] a);
        int p;
        logic [3:0] dv, en, pu;
        logic [31:0] e, c;
        p = (a[5:4] == 2'h3) ? 0 : int'(a[5:4]);
        arA <= a;
        arV <= 1'b1;
        do @(posedge clk_sys); while (arR !== 1'b1);
        arV <= 1'b0;
        rRdy <= 1'b1;
        do @(posedge clk_sys); while (rV !== 1'b1);
        rRdy <= 1'b0;
        dv = dirM[p][3:0] | ((p == 1 && serM[0]) ? (serM[1] ? 4'hF : 4'h7) : 4'h0);
        en = extEn[p*4 +: 4];
        pu = FITM[p*4 +: 4] & pullM[p][3:0] & ~dv;
        c = 32'hFFFFFFFF;
        if (respOf(a) != 32'h0) e = 32'h0;
        else if (a == 8'h30) e = serM;
        else if (a[3:0] == 4'h0) e = dirM[p];
        else if (a[3:0] == 4'h4) e = pullM[p];
        else begin
            e = {28'h0, (dv & dataM[p][3:0]) | (~dv & ((en & extLevel[p*4 +: 4]) | (~en & pu)))};
            c[3:0] = dv | en | pu;
        end
        chk({30'h0, rResp}, respOf(a));
        chk(rD & c, e & c);
    endtask
    task automatic pins();
        chk({20'h0, pinOe}, {20'h0, nib(dirM) & ~(ODM & nib(dataM))});
        chk({20'h0, pinOut & pinOe}, {20'h0, nib(dirM) & nib(dataM) & ~ODM});
        chk({20'h0, pinPullOn}, {20'h0, FITM & nib(pullM) & ~nib(dirM)});
    endtask

    // ======================================================================
    // main sequence
    // ======================================================================
    initial begin
        void'($urandom(32'hA215E676));
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        for (int a = 0; a <= 8'h30; a += 4) rd(8'(a));
        pins();
        $display("test reset values done");
        repeat (40) begin
            int p;
            p = $urandom % 3;
            wr(8'(p * 16), $urandom, ($urandom % 2) ? 4'hF : 4'hE);
            wr(8'(p * 16 + 4), $urandom, 4'hF);
            wr(8'(p * 16 + 8), $urandom, 4'hF);
            extLevel <= 12'($urandom);
            extEn <= 12'($urandom);
            repeat (3) @(posedge clk_sys); // two synchroniser stages plus capture
            pins();
            for (int o = 0; o <= 8; o += 4) rd(8'(p * 16 + o));
        end
        $display("test random pin settings done");
        // low ce holds off a pending write
        ce <= 1'b0;
        fork
            wr(8'h28, 32'h5, 4'hF);
            begin
                repeat (3) @(posedge clk_sys);
                ce <= 1'b1;
            end
        join
        wr(8'h2C, 32'hF, 4'hF);
        rd(8'h28);
        $display("test clock enable done");
        extEn <= 12'hFFF;
        extLevel <= 12'h0D5;
        wr(8'h30, 32'h1, 4'hF);
        wr(8'h10, 32'hF, 4'hF);
        wr(8'h18, 32'h6, 4'hF);
        repeat (3) @(posedge clk_sys);
        rd(8'h10);
        rd(8'h18);
        chk({31'h0, pinOe[4]}, 32'h0);
        chk({31'h0, pinPullOn[4]}, {31'h0, pullM[1][0]});
        chk({31'h0, pinOe[7]}, 32'h1);
        wr(8'h30, 32'h3, 4'hF);
        wr(8'h14, 32'h5, 4'hF);
        repeat (3) @(posedge clk_sys);
        rd(8'h18);
        chk({31'h0, pinPullOn[6]}, 32'h1);
        chk({31'h0, pinOe[6]}, 32'h0);
        chk({28'h0, serSl, serEn, sdi, sci}, 32'hF);
        wr(8'h30, 32'h0, 4'hF);
        repeat (2) @(posedge clk_sys);
        pins();
        $display("test serial sharing done");
        summarize();
    end
endmodule // biop_ctrl_bench
